/* src/clock_pin_regs.svh */
// Purpose: Offsets, field positions, reset values and timing for clock and pin control
// Assumes: Registers reached through the serial host port's register access
// Notes: Offsets are numbered within this block's own window
`ifndef CLOCK_PIN_REGS_SVH
`define CLOCK_PIN_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CLKCTL_OFS 12'h0E00
`define PINCFG_OFS 12'h0E04

// ----------------------------------------
// Clock source control fields
// ----------------------------------------
`define CLK_PLL_SEL_BIT 0
`define CLK_DISABLE_BIT 2
`define CLK_DEEP_SEL_BIT 3
`define CLK_SYSDIV_BIT 4
`define CLK_OUTDIV_LO 5
`define CLK_PLL_LOCK_BIT 8
`define CLK_STABLE_BIT 10
`define CLK_SYSRDY_BIT 12
`define CLK_WR_MASK 32'h0000_007D
`define CLK_RESET 32'h0000_0060

// ----------------------------------------
// Pin configuration fields
// ----------------------------------------
`define PIN_DIR0_BIT 0
`define PIN_STBY_BIT 6
`define PIN_AUX_PIN0_OUT_LATCH_BIT 8
`define PIN_LVL0_BIT 16
`define PIN_FUNC0_BIT 24
`define PIN_TXOD_BIT 28
`define PIN_SOF_BIT 29
`define PIN_IRQOD_BIT 30
`define PIN_WR_MASK 32'h7300_0343
`define PIN_RESET 32'h0300_0003

// ----------------------------------------
// Timing
// ----------------------------------------
`define MCLK_PERIOD_NS 5
`define CLK_START_NS 1000
`define CLK_START_CYC ((`CLK_START_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define PLL_LOCK_NS 500
`define PLL_LOCK_CYC ((`PLL_LOCK_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define SYSDIV_SETTLE_CYC 4

`endif

/* src/clock_pin_pkg.sv */
// Purpose: Types for the clock and pin control block
// Assumes: Used with clock_pin_regs.svh
// Notes: Types only
package clock_pin_pkg;
  // Operating state of the clock tree
  typedef enum logic [1:0] {
    CLK_RUN,
    CLK_SLEEP,
    CLK_DEEP
  } power_state_t;
  // Operation mode request codes seen by this block
  typedef enum logic [2:0] {
    OPM_NORMAL = 3'h0,
    OPM_SLEEP = 3'h1,
    OPM_CONFIG = 3'h4
  } op_mode_t;
endpackage

/* src/clock_and_pin_config.sv */
// Purpose: Clock source control and pin configuration registers with their logic
// Assumes: Host port gives single-cycle word writes with byte enables and reads
// Notes: Oscillator, PLL and divider outputs are control levels to the analog block
`timescale 1ns/1ps
`include "clock_pin_regs.svh"

module clock_and_pin_config (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [3:0] reg_be_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic [2:0] op_mode_request_i,
  output logic wake_to_config_o,
  input wire logic wake_irq_enable_i,
  input wire logic host_chip_select_n_i,
  input wire logic bus_receive_pin_i,
  input wire logic tx_flag_i,
  input wire logic tx_irq_en_i,
  input wire logic rx_flag_i,
  input wire logic rx_irq_en_i,
  input wire logic sof_pulse_i,
  input wire logic [1:0] aux_pin_i,
  output logic [1:0] aux_pin_o,
  output logic [1:0] aux_pin_oe_o,
  output logic clock_out_pin_o,
  output logic osc_enable_o,
  output logic pll_select_o,
  output logic sysclk_divisor_o,
  output logic deep_power_down_o,
  output logic irq_pin_open_drain_o,
  output logic bus_tx_pin_open_drain_o,
  output logic standby_pin_ctrl_enable_o
);

  // ----------------------------------------
  // Register write helper
  // ----------------------------------------
  // Byte-lane merge: lane 0 is the lowest byte address
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    merge = (res & wmask) | (old_v & ~wmask);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] clk_r, clk_nxt; // Clock control storage
  logic [31:0] pin_r, pin_nxt; // Pin configuration storage
  clock_pin_pkg::power_state_t pwr_r, pwr_nxt; // Sleep state
  logic [7:0] osc_cnt_r, osc_cnt_nxt; // Oscillator start counter
  logic [7:0] pll_cnt_r, pll_cnt_nxt; // PLL lock counter
  logic [2:0] div_cnt_r, div_cnt_nxt; // Divisor settle counter
  logic [2:0] odiv_cnt_r, odiv_cnt_nxt; // Clock output divider counter
  logic clock_out_pin_r, clock_out_pin_nxt; // Divided clock level
  logic wake_r, wake_nxt; // Wake pulse to controller
  logic [1:0] pin_s1_r, pin_s2_r; // Aux pin synchroniser
  logic [1:0] rx_s_r, cs_s_r; // Bus and select synchronisers, [0] first stage
  logic sof_r; // Registered start-of-frame mark
  logic [1:0] pin_out_r, pin_out_nxt; // Registered aux pin data and its next value
  logic [31:0] rdata_r, rdata_nxt; // Read data
  logic wr_clk, wr_pin, in_config, bus_wake, cs_wake;
  logic [3:0] div_limit; // Half-period count minus one
  logic [31:0] clk_view, pin_view;
  assign wr_clk = reg_wr_i && (reg_addr_i == `CLKCTL_OFS);
  assign wr_pin = reg_wr_i && (reg_addr_i == `PINCFG_OFS);
  assign in_config = (op_mode_request_i == clock_pin_pkg::OPM_CONFIG);
  // Bus wake needs the wake interrupt enabled
  assign bus_wake = !rx_s_r[1] && wake_irq_enable_i;
  assign cs_wake = !cs_s_r[1];
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Two flops on every pin input
  always_ff @(posedge mclk_i) begin
    pin_s1_r <= aux_pin_i;
    pin_s2_r <= pin_s1_r;
    rx_s_r <= {rx_s_r[0], bus_receive_pin_i};
    cs_s_r <= {cs_s_r[0], host_chip_select_n_i};
    sof_r <= sof_pulse_i;
  end

  // ----------------------------------------
  // Register and power state next values
  // ----------------------------------------
  always_comb begin
    logic [31:0] wm;
    wm = `CLK_WR_MASK;
    if (!in_config) begin
      wm[`CLK_PLL_SEL_BIT] = 1'b0;
      wm[`CLK_SYSDIV_BIT] = 1'b0;
    end
    clk_nxt = clk_r;
    pin_nxt = pin_r;
    pwr_nxt = pwr_r;
    wake_nxt = 1'b0;
    if (wr_clk) begin
      clk_nxt = merge(clk_r, reg_wdata_i, reg_be_i, wm);
    end
    if (wr_pin) begin
      pin_nxt = merge(pin_r, reg_wdata_i, reg_be_i, `PIN_WR_MASK);
    end
    case (pwr_r)
      clock_pin_pkg::CLK_RUN: begin
        // Sleep request or disable bit enters sleep; deep select bit picks variant, the select bit alone does nothing
        if (op_mode_request_i == clock_pin_pkg::OPM_SLEEP || clk_nxt[`CLK_DISABLE_BIT]) begin
          clk_nxt[`CLK_DISABLE_BIT] = 1'b1;
          pwr_nxt = clk_r[`CLK_DEEP_SEL_BIT] ? clock_pin_pkg::CLK_DEEP
                                              : clock_pin_pkg::CLK_SLEEP;
        end
      end
      clock_pin_pkg::CLK_SLEEP: begin
        // Light sleep keeps contents
        if (!clk_nxt[`CLK_DISABLE_BIT] || bus_wake) begin
          clk_nxt[`CLK_DISABLE_BIT] = 1'b0;
          pwr_nxt = clock_pin_pkg::CLK_RUN;
          wake_nxt = 1'b1;
        end
      end
      clock_pin_pkg::CLK_DEEP: begin
        // Deep sleep: contents lost, back to reset values on wake
        clk_nxt = `CLK_RESET | (32'h0000_0001 << `CLK_DISABLE_BIT);
        pin_nxt = `PIN_RESET;
        if (cs_wake || bus_wake) begin
          clk_nxt = `CLK_RESET;
          pwr_nxt = clock_pin_pkg::CLK_RUN;
          wake_nxt = 1'b1;
        end
      end
      default: begin
        pwr_nxt = clock_pin_pkg::CLK_RUN;
      end
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      clk_r <= `CLK_RESET;
      pin_r <= `PIN_RESET;
      pwr_r <= clock_pin_pkg::CLK_RUN;
      wake_r <= 1'b0;
    end else begin
      clk_r <= clk_nxt;
      pin_r <= pin_nxt;
      pwr_r <= pwr_nxt;
      wake_r <= wake_nxt;
    end
  end
  // ----------------------------------------
  // Clock readiness counters
  // ----------------------------------------
  always_comb begin
    osc_cnt_nxt = osc_cnt_r;
    pll_cnt_nxt = pll_cnt_r;
    div_cnt_nxt = div_cnt_r;
    if (pwr_r != clock_pin_pkg::CLK_RUN) begin
      osc_cnt_nxt = 8'h00; // Clock stopped
      pll_cnt_nxt = 8'h00;
    end else if (osc_cnt_r != 8'(`CLK_START_CYC)) begin
      osc_cnt_nxt = osc_cnt_r + 8'h01;
    end else if (!clk_r[`CLK_PLL_SEL_BIT]) begin
      pll_cnt_nxt = 8'h00; // PLL off
    end else if (pll_cnt_r != 8'(`PLL_LOCK_CYC)) begin
      pll_cnt_nxt = pll_cnt_r + 8'h01;
    end
    if (clk_nxt[`CLK_SYSDIV_BIT] != clk_r[`CLK_SYSDIV_BIT]) begin
      div_cnt_nxt = 3'(`SYSDIV_SETTLE_CYC);
    end else if (div_cnt_r != 3'h0) begin
      div_cnt_nxt = div_cnt_r - 3'h1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      osc_cnt_r <= 8'h00;
      pll_cnt_r <= 8'h00;
      div_cnt_r <= 3'h0;
    end else begin
      osc_cnt_r <= osc_cnt_nxt;
      pll_cnt_r <= pll_cnt_nxt;
      div_cnt_r <= div_cnt_nxt;
    end
  end

  // ----------------------------------------
  // Clock output divider
  // ----------------------------------------
  always_comb begin
    case (clk_r[`CLK_OUTDIV_LO +: 2])
      2'b11: div_limit = 4'h4; // Divide by 10
      2'b10: div_limit = 4'h1; // Divide by 4
      2'b01: div_limit = 4'h0; // Divide by 2
      default: div_limit = 4'hF; // Output held low
    endcase
    odiv_cnt_nxt = 3'h0;
    clock_out_pin_nxt = clock_out_pin_r;
    if (div_limit == 4'hF) begin
      clock_out_pin_nxt = 1'b0;
    end else if ({1'b0, odiv_cnt_r} >= div_limit) begin
      clock_out_pin_nxt = !clock_out_pin_r;
    end else begin
      odiv_cnt_nxt = odiv_cnt_r + 3'h1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      odiv_cnt_r <= 3'h0;
      clock_out_pin_r <= 1'b0;
    end else begin
      odiv_cnt_r <= odiv_cnt_nxt;
      clock_out_pin_r <= clock_out_pin_nxt;
    end
  end

  // ----------------------------------------
  // Aux pin drive
  // ----------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_aux
    logic irq_lvl;
    assign irq_lvl = (p == 0) ? (tx_flag_i && tx_irq_en_i)
                              : (rx_flag_i && rx_irq_en_i);
    // Interrupt function drives the active-low request, otherwise the latch
    assign pin_out_nxt[p] = !pin_r[`PIN_FUNC0_BIT + p] ? !irq_lvl
                                                      : pin_r[`PIN_AUX_PIN0_OUT_LATCH_BIT + p];
    // Interrupt function forces output; otherwise direction bit decides
    assign aux_pin_oe_o[p] = !pin_r[`PIN_FUNC0_BIT + p] ||
                             !pin_r[`PIN_DIR0_BIT + p];
  end
  assign aux_pin_o = pin_out_r;

  // ----------------------------------------
  // Read views
  // ----------------------------------------
  always_comb begin
    clk_view = clk_r & `CLK_WR_MASK;
    // Lock and stable flags drop at once when the clock stops, before the counters clear
    clk_view[`CLK_PLL_LOCK_BIT] = osc_enable_o && (pll_cnt_r == 8'(`PLL_LOCK_CYC));
    clk_view[`CLK_STABLE_BIT] = osc_enable_o && (osc_cnt_r == 8'(`CLK_START_CYC));
    clk_view[`CLK_SYSRDY_BIT] = (div_cnt_r == 3'h0);
    pin_view = pin_r & `PIN_WR_MASK;
    pin_view[`PIN_LVL0_BIT +: 2] = pin_s2_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_addr_i == `CLKCTL_OFS) begin
      rdata_nxt = clk_view;
    end else if (reg_addr_i == `PINCFG_OFS) begin
      rdata_nxt = pin_view;
    end
  end
  // Read data and aux pin data registers
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_r <= 32'h0000_0000;
      pin_out_r <= 2'b00;
    end else begin
      rdata_r <= rdata_nxt;
      pin_out_r <= pin_out_nxt;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_o = rdata_r;
  assign wake_to_config_o = wake_r;
  assign osc_enable_o = (pwr_r == clock_pin_pkg::CLK_RUN);
  assign pll_select_o = clk_r[`CLK_PLL_SEL_BIT];
  assign sysclk_divisor_o = clk_r[`CLK_SYSDIV_BIT];
  assign deep_power_down_o = (pwr_r == clock_pin_pkg::CLK_DEEP);
  assign clock_out_pin_o = pin_r[`PIN_SOF_BIT] ? sof_r : clock_out_pin_r;
  assign irq_pin_open_drain_o = pin_r[`PIN_IRQOD_BIT];
  assign bus_tx_pin_open_drain_o = pin_r[`PIN_TXOD_BIT];
  assign standby_pin_ctrl_enable_o = pin_r[`PIN_STBY_BIT];
endmodule

/* tb/clock_pin_sva.sv */
// Purpose: Port-level checks for clock and pin control
// Assumes: Single clock mclk_i, synchronous high reset srst_i
// Notes: Read data is judged against the address taken one edge earlier
`timescale 1ns/1ps
`include "clock_pin_regs.svh"

module clock_pin_sva (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [3:0] reg_be_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [2:0] op_mode_request_i,
  input wire logic wake_to_config_o,
  input wire logic [1:0] aux_pin_oe_o,
  input wire logic osc_enable_o,
  input wire logic pll_select_o,
  input wire logic sysclk_divisor_o,
  input wire logic deep_power_down_o
);
  // ----------------------------------------
  // Common clock and reset
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // Clock control write with byte lane 0 enabled
  wire clk_wr = reg_wr_i && reg_addr_i == `CLKCTL_OFS && reg_be_i[0];

  property p_unmapped;
    !$past(srst_i) && !($past(reg_addr_i) inside {`CLKCTL_OFS, `PINCFG_OFS})
      |-> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_clk_zero;
    !$past(srst_i) && $past(reg_addr_i) == `CLKCTL_OFS |-> (reg_rdata_o & 32'hFFFF_EA82) == 0;
  endproperty
  a_clk_zero: assert property (p_clk_zero) else $error("clock ctl spare bit set");
  property p_pin_zero;
    !$past(srst_i) && $past(reg_addr_i) == `PINCFG_OFS |-> (reg_rdata_o & 32'h8CFC_FCBC) == 0;
  endproperty
  a_pin_zero: assert property (p_pin_zero) else $error("pin cfg spare bit set");
  property p_sleep;
    clk_wr && reg_wdata_i[2] |=> !osc_enable_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("clock still on after disable");
  property p_refuse;
    clk_wr && !reg_wdata_i[2] && op_mode_request_i != 3'h4
      |=> $stable({pll_select_o, sysclk_divisor_o});
  endproperty
  a_refuse: assert property (p_refuse) else $error("locked bit changed");
  property p_deep;
    deep_power_down_o |-> !osc_enable_o;
  endproperty
  a_deep: assert property (p_deep) else $error("clock on in deep sleep");
  property p_wake;
    wake_to_config_o |=> !wake_to_config_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake pulse too long");
  property p_oe;
    !$past(srst_i) && $past(reg_addr_i) == `PINCFG_OFS
      |-> $past(aux_pin_oe_o) == ~(reg_rdata_o[25:24] & reg_rdata_o[1:0]);
  endproperty
  a_oe: assert property (p_oe) else $error("pin drive enable wrong");
  property p_stable;
    !$past(srst_i) && $past(reg_addr_i) == `CLKCTL_OFS && !$past(osc_enable_o)
      |-> !reg_rdata_o[10];
  endproperty
  a_stable: assert property (p_stable) else $error("stable flag with clock off");

  // Main scenarios reached
  c_wake: cover property (wake_to_config_o);
  c_deep: cover property (deep_power_down_o);
  c_drive: cover property (aux_pin_oe_o == 2'b11);
endmodule

bind clock_and_pin_config clock_pin_sva clock_pin_sva_i (
  .mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .op_mode_request_i(op_mode_request_i), .wake_to_config_o(wake_to_config_o),
  .aux_pin_oe_o(aux_pin_oe_o), .osc_enable_o(osc_enable_o), .pll_select_o(pll_select_o),
  .sysclk_divisor_o(sysclk_divisor_o), .deep_power_down_o(deep_power_down_o));

/* tb/test_clock_and_pin_config.sv */
// Purpose: Self-checking bench for clock and pin control
// Assumes: Inputs change on the falling edge of mclk_i
// Notes: Each scenario is a task that judges its own results
`timescale 1ns/1ps
`include "clock_pin_regs.svh"

module test_clock_and_pin_config;
  logic mclk_i, srst_i, reg_wr_i, wake_irq_enable_i, host_chip_select_n_i, bus_receive_pin_i;
  logic tx_flag_i, tx_irq_en_i, rx_flag_i, rx_irq_en_i, sof_pulse_i;
  logic wake_to_config_o, clock_out_pin_o, osc_enable_o, pll_select_o, sysclk_divisor_o;
  logic deep_power_down_o, irq_pin_open_drain_o, bus_tx_pin_open_drain_o;
  logic standby_pin_ctrl_enable_o;
  logic [11:0] reg_addr_i;
  logic [3:0] reg_be_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [2:0] op_mode_request_i;
  logic [1:0] aux_pin_i, aux_pin_o, aux_pin_oe_o;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  clock_and_pin_config clock_and_pin_config_i (
    .mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .op_mode_request_i(op_mode_request_i), .wake_to_config_o(wake_to_config_o),
    .wake_irq_enable_i(wake_irq_enable_i), .host_chip_select_n_i(host_chip_select_n_i),
    .bus_receive_pin_i(bus_receive_pin_i), .tx_flag_i(tx_flag_i), .tx_irq_en_i(tx_irq_en_i),
    .rx_flag_i(rx_flag_i), .rx_irq_en_i(rx_irq_en_i), .sof_pulse_i(sof_pulse_i),
    .aux_pin_i(aux_pin_i), .aux_pin_o(aux_pin_o), .aux_pin_oe_o(aux_pin_oe_o),
    .clock_out_pin_o(clock_out_pin_o), .osc_enable_o(osc_enable_o),
    .pll_select_o(pll_select_o), .sysclk_divisor_o(sysclk_divisor_o),
    .deep_power_down_o(deep_power_down_o), .irq_pin_open_drain_o(irq_pin_open_drain_o),
    .bus_tx_pin_open_drain_o(bus_tx_pin_open_drain_o),
    .standby_pin_ctrl_enable_o(standby_pin_ctrl_enable_o));

  // ----------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // Cuts a hung run short
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      test_done;
    end
  end
  task automatic test_done;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // One-cycle register write after one idle edge, so two writes never share a step
  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    wt(1);
    reg_addr_i = a;
    reg_be_i = be;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    wt(1);
    reg_wr_i = 1'b0;
  endtask
  // Read one cycle after the address and compare the masked value
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr_i = a;
    wt(1);
    chk((reg_rdata_o & m) === e, "read value");
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`CLKCTL_OFS, 32'hFFFF_FFFF, 32'h0000_1060);
    rd(`PINCFG_OFS, 32'hFFFC_FFFF, 32'h0300_0003);
    wr(12'h0E08, 4'hF, 32'hFFFF_FFFF);
    rd(12'h0E08, 32'hFFFF_FFFF, 32'h0000_0000);
    wt(210);
    rd(`CLKCTL_OFS, 32'h0000_0500, 32'h0000_0400);
  endtask
  task automatic t_pll;
    wr(`CLKCTL_OFS, 4'h1, 32'h0000_0071);
    chk(pll_select_o === 1'b1 && sysclk_divisor_o === 1'b1, "pll select");
    wt(110);
    rd(`CLKCTL_OFS, 32'h0000_0100, 32'h0000_0100);
    op_mode_request_i = 3'h0;
    wr(`CLKCTL_OFS, 4'h1, 32'h0000_0060);
    chk(pll_select_o === 1'b1 && sysclk_divisor_o === 1'b1, "locked bits");
  endtask
  task automatic t_div;
    int n;
    logic p;
    int d [3];
    d = '{2, 4, 10};
    for (int c = 1; c < 4; c++) begin
      wr(`CLKCTL_OFS, 4'h1, 32'(c) << 5);
      wt(12);
      n = 0;
      p = clock_out_pin_o;
      repeat (40) begin
        wt(1);
        n += int'(clock_out_pin_o === 1'b1 && p !== 1'b1);
        p = clock_out_pin_o;
      end
      chk(n == 40 / d[c-1], "clock out rate");
    end
  endtask
  task automatic t_sof;
    bit seen;
    wr(`PINCFG_OFS, 4'h8, 32'h7300_0000);
    wt(4);
    chk(clock_out_pin_o === 1'b0, "frame mark idle");
    chk(irq_pin_open_drain_o === 1'b1 && bus_tx_pin_open_drain_o === 1'b1, "drain");
    sof_pulse_i = 1'b1;
    wt(1);
    sof_pulse_i = 1'b0;
    seen = 0;
    repeat (4) begin
      seen |= (clock_out_pin_o === 1'b1);
      wt(1);
    end
    chk(seen, "frame mark missing");
    wr(`PINCFG_OFS, 4'h8, 32'h0300_0000);
  endtask
  task automatic t_gpio;
    aux_pin_i = 2'b01;
    wr(`PINCFG_OFS, 4'h1, 32'h0000_0040);
    chk(standby_pin_ctrl_enable_o === 1'b1, "standby control");
    wr(`PINCFG_OFS, 4'h2, 32'h0000_0200);
    wt(4);
    chk(aux_pin_oe_o === 2'b11 && aux_pin_o === 2'b10, "gpio drive");
    rd(`PINCFG_OFS, 32'h0003_0303, 32'h0001_0200);
    wr(`PINCFG_OFS, 4'h1, 32'h0000_0001);
    chk(aux_pin_oe_o === 2'b10, "gpio direction");
  endtask
  task automatic t_irq;
    wr(`PINCFG_OFS, 4'h8, 32'h0000_0000);
    wr(`PINCFG_OFS, 4'h1, 32'h0000_0003);
    tx_flag_i = 1'b1;
    tx_irq_en_i = 1'b1;
    rx_flag_i = 1'b1;
    wt(3);
    chk(aux_pin_oe_o === 2'b11, "irq pin forced out");
    chk(aux_pin_o === 2'b10, "tx irq only");
    rx_irq_en_i = 1'b1;
    wt(3);
    chk(aux_pin_o === 2'b00, "both irq");
  endtask
  task automatic t_sleep;
    bit seen;
    op_mode_request_i = 3'h4;
    wr(`CLKCTL_OFS, 4'h1, 32'h0000_0064);
    chk(osc_enable_o === 1'b0, "light sleep");
    wr(`CLKCTL_OFS, 4'h1, 32'h0000_0060);
    seen = 0;
    repeat (4) begin
      seen |= (wake_to_config_o === 1'b1);
      wt(1);
    end
    chk(seen && osc_enable_o === 1'b1, "wake by clear");
    op_mode_request_i = 3'h1;
    wt(3);
    chk(osc_enable_o === 1'b0 && deep_power_down_o === 1'b0, "light by request");
    op_mode_request_i = 3'h4;
    wake_irq_enable_i = 1'b1;
    bus_receive_pin_i = 1'b0;
    wt(6);
    bus_receive_pin_i = 1'b1;
    chk(osc_enable_o === 1'b1, "bus wake");
  endtask
  task automatic t_deep;
    wr(`CLKCTL_OFS, 4'h1, 32'h0000_0068);
    chk(deep_power_down_o === 1'b0 && osc_enable_o === 1'b1, "select only");
    op_mode_request_i = 3'h1;
    wt(3);
    chk(deep_power_down_o === 1'b1 && osc_enable_o === 1'b0, "deep sleep");
    op_mode_request_i = 3'h4;
    host_chip_select_n_i = 1'b0;
    wt(6);
    host_chip_select_n_i = 1'b1;
    chk(osc_enable_o === 1'b1, "select wake");
    rd(`PINCFG_OFS, 32'hFFFC_FFFF, 32'h0300_0003);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reg_wr_i, wake_irq_enable_i, tx_flag_i, tx_irq_en_i, rx_flag_i, rx_irq_en_i} = '0;
    {sof_pulse_i, reg_be_i, reg_wdata_i, aux_pin_i} = '0;
    reg_addr_i = 12'h000;
    op_mode_request_i = 3'h4;
    host_chip_select_n_i = 1'b1;
    bus_receive_pin_i = 1'b1;
    srst_i = 1'b1;
    wt(16);
    srst_i = 1'b0;
    t_regs;
    t_pll;
    t_div;
    t_sof;
    t_gpio;
    t_irq;
    t_sleep;
    t_deep;
    test_done;
  end
endmodule
